/* dv/sbg_peer.sv */
`timescale 1ns/100ps
// ==========================================================
// Remote serial peer: holds the receive line and sends start edges
module sbg_peer #(
  parameter int LOW_LEN = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Command from the bench
  input wire logic start_req,
  // Serial line
  output logic rx_pin,
  input wire logic transmit_clock_pin,
  // What the peer last took from the line
  output logic line_seen
);
  int cnt_r;
  logic last_tx_r;
  assign line_seen = last_tx_r;
  // Line idles high; a start request pulls it low for LOW_LEN cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 0;
      rx_pin <= 1'b1;
    end else if (start_req) begin
      cnt_r <= LOW_LEN;
      rx_pin <= 1'b0;
    end else if (cnt_r > 1) begin
      cnt_r <= cnt_r - 1;
    end else begin
      cnt_r <= 0;
      rx_pin <= 1'b1;
    end
  end
  // Peer samples the shared data line on the one clock edge both use
  always_ff @(posedge pclk) begin
    last_tx_r <= transmit_clock_pin;
  end
endmodule

/* dv/serial_baud_rate_generator_test.sv */
`timescale 1ns/100ps
// ==========================================================
// Bench for the bit-rate generator and its control registers
module serial_baud_rate_generator_test;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic pready, pslverr, ev, rx_pin, tx_pin, tx_data_i, tx_empty;
  logic rx_busy_i, abd_done, abd_ovf, bit_tick, sync_rise, abd_act;
  logic rx_flag, irq, start_req, line_seen;
  logic [2:0] rx_status_i;
  int err_total, n_compared, cyc;

  // ==========================================================
  // Clock, reset and time limit
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Ceiling sized well above the longest rate checks
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      summarize();
    end
  end

  sbg_baud_gen u_sbg_baud_gen (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin(rx_pin), .transmit_clock_pin(tx_pin),
    .tx_data_i(tx_data_i), .tx_shift_empty_i(tx_empty),
    .rx_busy_i(rx_busy_i), .rx_status_i(rx_status_i),
    .autobaud_done_i(abd_done), .autobaud_ovf_i(abd_ovf),
    .bit_tick(bit_tick), .sync_rising_edge(sync_rise),
    .autobaud_active(abd_act), .receive_interrupt_flag(rx_flag),
    .irq(irq));
  sbg_peer u_sbg_peer (.pclk(pclk), .presetn(presetn),
    .start_req(start_req), .rx_pin(rx_pin), .transmit_clock_pin(tx_pin),
    .line_seen(line_seen));

  // ==========================================================
  // Shared helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  // A slave that never answers is caught by the bench timeout
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
    chk(ev, 32'h0);
  endtask
  // Cycles between two bit ticks
  task period(input logic [31:0] exp);
    int k, p;
    k = 0;
    p = 0;
    while (bit_tick !== 1'b1 && k < 9000) begin
      @(posedge pclk);
      k++;
    end
    do begin
      @(posedge pclk);
      p++;
    end while (bit_tick !== 1'b1 && p < 9000);
    chk(p, exp);
  endtask

  // ==========================================================
  // Scenarios
  task t_reset();
    rd(sbg_pkg::OFF_BAUD_CTRL, 32'h40);
    rd(sbg_pkg::OFF_TX_CTRL, 32'h02);
    rd(sbg_pkg::OFF_RX_CTRL, 32'h05);
    apb(1'b0, 8'h1C, 32'h0);
    chk(ev, 32'h1);
    chk(rv, 32'h0);
  endtask
  task t_reserved();
    wr(sbg_pkg::OFF_BAUD_CTRL, 32'hE4);
    rd(sbg_pkg::OFF_BAUD_CTRL, 32'h40);
    rx_busy_i <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(sbg_pkg::OFF_BAUD_CTRL, 32'h00);
    rx_busy_i <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(sbg_pkg::OFF_BAUD_CTRL, 32'h40);
  endtask
  task t_rates();
    logic [7:0] bc[6], tc[6];
    logic [31:0] ex[6];
    bc = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
    tc = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h14, 8'h10};
    ex = '{32'd192, 32'd48, 32'd4144, 32'd1036, 32'd12, 32'd1036};
    wr(sbg_pkg::OFF_RX_CTRL, 32'h80);
    wr(sbg_pkg::OFF_DIV_HIGH, 32'h01);
    wr(sbg_pkg::OFF_DIV_LOW, 32'h02);
    for (int i = 0; i < 6; i++) begin
      wr(sbg_pkg::OFF_BAUD_CTRL, {24'h0, bc[i]});
      wr(sbg_pkg::OFF_TX_CTRL, {24'h0, tc[i]});
      period(ex[i]);
    end
  endtask
  // Without the clear, the old count would tick about 90 cycles in
  task t_clear();
    int p;
    wr(sbg_pkg::OFF_BAUD_CTRL, 32'h00);
    wr(sbg_pkg::OFF_TX_CTRL, 32'h00);
    wr(sbg_pkg::OFF_DIV_LOW, 32'd200);
    repeat (100) @(posedge pclk);
    wr(sbg_pkg::OFF_DIV_LOW, 32'h02);
    p = 0;
    while (bit_tick !== 1'b1 && p < 400) begin
      @(posedge pclk);
      p++;
    end
    chk(p >= 190 && p <= 194, 32'h1);
  endtask
  task t_polarity();
    tx_data_i <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(tx_pin, 32'h1);
    chk(line_seen, 32'h1);
    wr(sbg_pkg::OFF_BAUD_CTRL, 32'h10);
    repeat (3) @(posedge pclk);
    chk(tx_pin, 32'h0);
    chk(line_seen, 32'h0);
    chk(sync_rise, 32'h0);
    wr(sbg_pkg::OFF_TX_CTRL, 32'h10);
    repeat (3) @(posedge pclk);
    chk(sync_rise, 32'h1);
    chk(tx_pin, 32'h1);
    wr(sbg_pkg::OFF_BAUD_CTRL, 32'h00);
    repeat (3) @(posedge pclk);
    chk(sync_rise, 32'h0);
    wr(sbg_pkg::OFF_TX_CTRL, 32'h00);
  endtask
  task t_wake();
    int k;
    k = 0;
    wr(sbg_pkg::OFF_IRQ_MASK, 32'h01);
    wr(sbg_pkg::OFF_BAUD_CTRL, 32'h02);
    @(posedge pclk) start_req <= 1'b1;
    @(posedge pclk) start_req <= 1'b0;
    while (rx_flag !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    chk(rx_flag, 32'h1);
    repeat (3) @(posedge pclk);
    chk(irq, 32'h1);
    rd(sbg_pkg::OFF_BAUD_CTRL, 32'h40);
    rd(sbg_pkg::OFF_IRQ_STAT, 32'h01);
    repeat (3) @(posedge pclk);
    chk(irq, 32'h0);
    rd(sbg_pkg::OFF_IRQ_STAT, 32'h00);
  endtask
  task t_autobaud();
    wr(sbg_pkg::OFF_IRQ_MASK, 32'h00);
    wr(sbg_pkg::OFF_BAUD_CTRL, 32'h01);
    repeat (3) @(posedge pclk);
    chk(abd_act, 32'h1);
    @(posedge pclk) abd_ovf <= 1'b1;
    @(posedge pclk) abd_ovf <= 1'b0;
    rd(sbg_pkg::OFF_BAUD_CTRL, 32'hC1);
    @(posedge pclk) abd_done <= 1'b1;
    @(posedge pclk) abd_done <= 1'b0;
    rd(sbg_pkg::OFF_BAUD_CTRL, 32'hC0);
    chk(abd_act, 32'h0);
    chk(irq, 32'h0);
    rd(sbg_pkg::OFF_IRQ_STAT, 32'h06);
    wr(sbg_pkg::OFF_TX_CTRL, 32'h10);
    wr(sbg_pkg::OFF_BAUD_CTRL, 32'h01);
    repeat (3) @(posedge pclk);
    chk(abd_act, 32'h0);
  endtask

  task summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, tx_data_i, rx_busy_i} = 5'h00;
    {abd_done, abd_ovf, start_req} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tx_empty = 1'b1;
    rx_status_i = 3'h5;
    err_total = 0;
    n_compared = 0;
    cyc = 0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_reserved();
    t_rates();
    t_clear();
    t_polarity();
    t_wake();
    t_autobaud();
    summarize();
  end
endmodule

/* hdl/sbg_baud_gen.sv */
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
// Behaviour
// R1 - The divisor timer is 8 bits wide after reset and 16 bits when width select is set.
// R2 - The high and low divisor bytes set the reload period of the bit-rate timer.
// R3 - Async multiplier follows high speed and width select; sync ignores high speed.
// R4 - Any divisor write clears the bit-rate timer at once.
// R5 - Rates are clk/(64(n+1)) 8-bit slow async, clk/(16(n+1)) 16-bit slow, clk/(4(n+1)) sync.
// R6 - Fast async gives clk/(16(n+1)) in 8-bit and clk/(4(n+1)) in 16-bit.
// R7 - The auto-baud overflow flag shows a measurement overflow, read only, reset 0.
// R8 - The receive-idle flag is 1 while idle and 0 while receiving, reset 1.
// R9 - In async mode polarity 1 inverts the data driven to the transmit pin.
// R10 - In sync mode polarity selects the data clock edge, 1 rising, 0 falling.
// R11 - Wake-up waits for a falling receive edge, raises the receive flag, then clears.
// R12 - Auto-baud enable starts detection in async mode and self-clears on completion.
// R13 - Unused baud control bits ignore writes and read 0.
// R14 - Software checks the idle flag before changing the system clock.
// R15 - Software prefers high speed or 16-bit divisor to reduce rate error.
// R16 - In 8-bit mode only the low divisor byte sets the period.
module sbg_baud_gen (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  input wire logic rx_pin,
  output logic transmit_clock_pin,
  // Shift logic side
  input wire logic tx_data_i,
  input wire logic tx_shift_empty_i,
  input wire logic rx_busy_i,
  input wire logic [2:0] rx_status_i,
  input wire logic autobaud_done_i,
  input wire logic autobaud_ovf_i,
  output logic bit_tick,
  output logic sync_rising_edge,
  output logic autobaud_active,
  output logic receive_interrupt_flag,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Register state
  logic [7:0] bcon_r;
  logic [7:0] txc_r;
  logic [7:0] rxc_r;
  logic [7:0] divisor_low_byte_r;
  logic [7:0] divisor_high_byte_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic abd_ovf_r;
  logic rx_idle_r;
  sbg_pkg::sbg_mode_s mode;
  sbg_pkg::sbg_apb_rsp_s rsp_r;
  logic wr_acc;
  logic rd_acc;
  logic div_wr;
  logic [7:0] rd_byte;
  logic mapped;

  // Field view of the control registers
  assign mode = {txc_r[sbg_pkg::TX_SYNC],
                 txc_r[sbg_pkg::TX_HIGH_SPEED],
                 bcon_r[sbg_pkg::BC_WIDTH],
                 bcon_r[sbg_pkg::BC_POL]};

  // Access phase strobes; effects land on the completing edge
  assign wr_acc = psel && penable && pready && pwrite;
  assign rd_acc = psel && penable && pready && !pwrite;
  assign div_wr = wr_acc && (paddr == sbg_pkg::OFF_DIV_LOW ||
                             paddr == sbg_pkg::OFF_DIV_HIGH);

  // ==========================================================
  // Read mux; unused baud control bits fall out as zero
  always_comb begin
    mapped = 1'b1;
    rd_byte = 8'h00;
    unique case (paddr)
      sbg_pkg::OFF_BAUD_CTRL: begin
        rd_byte = bcon_r & sbg_pkg::BC_WR_MASK; // R13
        rd_byte[sbg_pkg::BC_ABD_OVF] = abd_ovf_r; // R7
        rd_byte[sbg_pkg::BC_RX_IDLE] = rx_idle_r; // R8
      end
      sbg_pkg::OFF_RX_CTRL: begin
        rd_byte = {rxc_r[7:sbg_pkg::RX_STAT_W], rx_status_i};
      end
      sbg_pkg::OFF_DIV_LOW: rd_byte = divisor_low_byte_r;
      sbg_pkg::OFF_DIV_HIGH: rd_byte = divisor_high_byte_r;
      sbg_pkg::OFF_TX_CTRL: begin
        rd_byte = txc_r;
        rd_byte[sbg_pkg::TX_SHIFT_EMPTY] = tx_shift_empty_i;
      end
      sbg_pkg::OFF_IRQ_STAT: rd_byte = {5'h00, irq_stat_r};
      sbg_pkg::OFF_IRQ_MASK: rd_byte = {5'h00, irq_mask_r};
      default: mapped = 1'b0;
    endcase
  end

  // APB answer: one wait-free access phase, data captured in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_r <= '0;
    end else begin
      rsp_r.ready <= psel && !penable;
      rsp_r.slverr <= psel && !penable && !mapped;
      rsp_r.rdata <= (psel && !penable && !pwrite) ?
                     {24'h000000, rd_byte} : 32'h00000000;
    end
  end
  assign pready = rsp_r.ready;
  assign pslverr = rsp_r.slverr;
  assign prdata = rsp_r.rdata;

  // ==========================================================
  // Divisor and mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divisor_low_byte_r <= sbg_pkg::REG_RST;
      divisor_high_byte_r <= sbg_pkg::REG_RST;
      txc_r <= sbg_pkg::REG_RST;
      rxc_r <= sbg_pkg::REG_RST;
      irq_mask_r <= '0;
    end else if (wr_acc) begin
      if (paddr == sbg_pkg::OFF_DIV_LOW) begin
        divisor_low_byte_r <= pwdata[7:0];
      end
      if (paddr == sbg_pkg::OFF_DIV_HIGH) begin
        divisor_high_byte_r <= pwdata[7:0];
      end
      if (paddr == sbg_pkg::OFF_TX_CTRL) begin
        txc_r <= pwdata[7:0] & sbg_pkg::TX_WR_MASK;
      end
      if (paddr == sbg_pkg::OFF_RX_CTRL) begin
        rxc_r <= pwdata[7:0] & sbg_pkg::RX_WR_MASK;
      end
      if (paddr == sbg_pkg::OFF_IRQ_MASK) begin
        irq_mask_r <= pwdata[sbg_pkg::IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // Receive pin synchroniser; only agreeing late stages count
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_s3_r;
  logic rx_level_r;
  logic rx_fall;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_level_r <= 1'b1;
    end else begin
      rx_s1_r <= rx_pin;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      if (rx_s2_r == rx_s3_r) begin
        rx_level_r <= rx_s3_r;
      end
    end
  end
  assign rx_fall = rx_level_r && (rx_s2_r == rx_s3_r) && !rx_s3_r;

  // ==========================================================
  // Baud control: software bits plus hardware self-clears
  logic wake_hit;
  logic abd_finish;
  assign wake_hit = bcon_r[sbg_pkg::BC_WAKE] && !mode.sync_mode &&
                    rx_fall;
  assign abd_finish = bcon_r[sbg_pkg::BC_ABD_EN] && !mode.sync_mode &&
                      autobaud_done_i;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcon_r <= sbg_pkg::REG_RST;
    end else begin
      if (wr_acc && paddr == sbg_pkg::OFF_BAUD_CTRL) begin
        bcon_r <= pwdata[7:0] & sbg_pkg::BC_WR_MASK; // R13
      end
      // Hardware clear wins so a finished event never re-arms
      if (wake_hit) begin
        bcon_r[sbg_pkg::BC_WAKE] <= 1'b0; // R11
      end
      if (abd_finish) begin
        bcon_r[sbg_pkg::BC_ABD_EN] <= 1'b0; // R12
      end
    end
  end

  // Auto-baud overflow flag, cleared when detection is restarted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abd_ovf_r <= 1'b0;
    end else if (autobaud_ovf_i && !mode.sync_mode) begin
      abd_ovf_r <= 1'b1; // R7
    end else if (wr_acc && paddr == sbg_pkg::OFF_BAUD_CTRL &&
                 pwdata[sbg_pkg::BC_ABD_EN]) begin
      abd_ovf_r <= 1'b0;
    end
  end

  // Receive idle flag; software polls it before clock changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_idle_r <= 1'b1;
    end else begin
      rx_idle_r <= !rx_busy_i; // R8 R14
    end
  end

  // ==========================================================
  // Bit-rate generator: prescaler then divisor timer
  logic [5:0] pre_top;
  logic [15:0] period;
  logic [5:0] pre_r;
  logic [15:0] bit_rate_timer_r;
  logic gen_run;
  always_comb begin
    // Sync ignores high speed; async picks by both bits
    if (mode.sync_mode) begin
      pre_top = sbg_pkg::PRE_X4; // R3 R5
    end else if (mode.width16 && mode.high_speed) begin
      pre_top = sbg_pkg::PRE_X4; // R6
    end else if (mode.width16 || mode.high_speed) begin
      pre_top = sbg_pkg::PRE_X16; // R5 R6
    end else begin
      pre_top = sbg_pkg::PRE_X64; // R5
    end
  end
  // High byte only counts in 16-bit mode
  assign period = mode.width16 ?
                  {divisor_high_byte_r, divisor_low_byte_r} :
                  {8'h00, divisor_low_byte_r}; // R1 R2 R16
  assign gen_run = rxc_r[sbg_pkg::RX_PORT_EN];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= sbg_pkg::PRE_ZERO;
      bit_rate_timer_r <= sbg_pkg::TMR_ZERO;
      bit_tick <= 1'b0;
    end else if (div_wr || !gen_run) begin
      // New rate starts from zero, no wait for overflow
      pre_r <= sbg_pkg::PRE_ZERO; // R4
      bit_rate_timer_r <= sbg_pkg::TMR_ZERO; // R4
      bit_tick <= 1'b0;
    end else if (pre_r >= pre_top) begin
      pre_r <= sbg_pkg::PRE_ZERO;
      if (bit_rate_timer_r >= period) begin
        bit_rate_timer_r <= sbg_pkg::TMR_ZERO; // R2
        bit_tick <= 1'b1;
      end else begin
        bit_rate_timer_r <= bit_rate_timer_r + 16'h0001;
        bit_tick <= 1'b0;
      end
    end else begin
      pre_r <= pre_r + 6'h01;
      bit_tick <= 1'b0;
    end
  end

  // ==========================================================
  // Line side outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_clock_pin <= 1'b1;
      sync_rising_edge <= 1'b0;
      autobaud_active <= 1'b0;
      receive_interrupt_flag <= 1'b0;
    end else begin
      // Async only: inversion would corrupt a sync clock
      transmit_clock_pin <= tx_data_i ^
                            (mode.polarity && !mode.sync_mode); // R9
      sync_rising_edge <= mode.polarity && mode.sync_mode; // R10
      autobaud_active <= bcon_r[sbg_pkg::BC_ABD_EN] &&
                         !mode.sync_mode; // R12
      receive_interrupt_flag <= wake_hit; // R11
    end
  end

  // ==========================================================
  // Interrupt status: sticky, read clears, a new event beats the clear
  logic [2:0] irq_ev;
  assign irq_ev = {autobaud_ovf_i && !mode.sync_mode, abd_finish,
                   wake_hit};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
    end else if (rd_acc && paddr == sbg_pkg::OFF_IRQ_STAT) begin
      // Clear only what the read returned; setup-cycle events survive
      irq_stat_r <= (irq_stat_r & ~rsp_r.rdata[sbg_pkg::IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_r <= irq_stat_r | irq_ev;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ==========================================================
  // Checks; one clock domain, so one shared clocking and reset guard
  default clocking cb_chk @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_TIMER_CLEAR: assert property (div_wr |=> pre_r == 6'h00 && // R4
    bit_rate_timer_r == 16'h0000)
    else $error("divisor write did not clear the timer");
  AST_WIDTH8: assert property (!mode.width16 |-> // R1 R16
    period[15:8] == 8'h00)
    else $error("high byte used in 8-bit mode");
  // A width change leaves the count above a shorter period for one tick
  AST_PERIOD: assert property (bit_tick |-> // R2
    $past(bit_rate_timer_r) >= $past(period) &&
    $past(pre_r) >= $past(pre_top) && bit_rate_timer_r == 16'h0000)
    else $error("tick not at divisor period");
  AST_SYNC_X4: assert property (mode.sync_mode |-> // R3 R5
    pre_top == sbg_pkg::PRE_X4)
    else $error("sync multiplier not 4");
  AST_ASYNC_X64: assert property (!mode.sync_mode && // R5
    !mode.width16 && !mode.high_speed |-> pre_top == sbg_pkg::PRE_X64)
    else $error("slow 8-bit multiplier not 64");
  AST_ASYNC_HS: assert property (!mode.sync_mode && mode.high_speed |-> // R6
    pre_top == (mode.width16 ? sbg_pkg::PRE_X4 : sbg_pkg::PRE_X16))
    else $error("high speed multiplier wrong");
  AST_ABD_OVF: assert property (autobaud_ovf_i && !mode.sync_mode |=> // R7
    abd_ovf_r)
    else $error("overflow flag not set");
  AST_IDLE: assert property (rx_busy_i |=> !rx_idle_r) // R8
    else $error("idle flag high while receiving");
  // Skip the edge that still ran the reset branch
  AST_TX_INV: assert property ($past(presetn) |-> // R9
    transmit_clock_pin == ($past(tx_data_i) ^
    ($past(mode.polarity) && !$past(mode.sync_mode))))
    else $error("transmit pin polarity wrong");
  AST_SYNC_EDGE: assert property (mode.sync_mode |=> // R10
    sync_rising_edge == $past(mode.polarity))
    else $error("sync edge select wrong");
  AST_WAKE: assert property (wake_hit |=> receive_interrupt_flag && // R11
    !bcon_r[sbg_pkg::BC_WAKE])
    else $error("wake-up did not flag and clear");
  AST_ABD_CLR: assert property (abd_finish |=> // R12
    !bcon_r[sbg_pkg::BC_ABD_EN])
    else $error("auto-baud enable not cleared");
  AST_RSVD: assert property (rd_acc && // R13
    paddr == sbg_pkg::OFF_BAUD_CTRL |-> prdata[5] == 1'b0 &&
    prdata[2] == 1'b0 && prdata[31:8] == 24'h000000)
    else $error("reserved bit read high");
  AST_BCON_RSVD: assert property (bcon_r[5] == 1'b0 && // R13
    bcon_r[2] == 1'b0 && bcon_r[7:6] == 2'b00)
    else $error("reserved baud control bit stored");
  COV_TICK16: cover property (bit_tick && mode.width16 && !mode.sync_mode);
  COV_WAKE: cover property (wake_hit);
  COV_ABD: cover property (abd_finish);
  COV_IRQ: cover property (irq);

endmodule

/* hdl/sbg_pkg.sv */
package sbg_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] OFF_BAUD_CTRL = 8'h00;
  localparam logic [7:0] OFF_RX_CTRL = 8'h04;
  localparam logic [7:0] OFF_DIV_LOW = 8'h08;
  localparam logic [7:0] OFF_DIV_HIGH = 8'h0C;
  localparam logic [7:0] OFF_TX_CTRL = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  // ==========================================================
  // Baud control bit positions
  localparam int BC_ABD_OVF = 7;
  localparam int BC_RX_IDLE = 6;
  localparam int BC_POL = 4;
  localparam int BC_WIDTH = 3;
  localparam int BC_WAKE = 1;
  localparam int BC_ABD_EN = 0;
  // Transmit control bit positions
  localparam int TX_SYNC = 4;
  localparam int TX_HIGH_SPEED = 2;
  localparam int TX_SHIFT_EMPTY = 1;
  // Receive control bit positions
  localparam int RX_PORT_EN = 7;
  localparam int RX_STAT_W = 3;
  // Interrupt status bit positions
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_ABD_DONE = 1;
  localparam int IRQ_ABD_OVF = 2;
  localparam int IRQ_W = 3;
  // ==========================================================
  // Writable masks and reset values
  localparam logic [7:0] BC_WR_MASK = 8'h1B;
  localparam logic [7:0] TX_WR_MASK = 8'hFD;
  localparam logic [7:0] RX_WR_MASK = 8'hF8;
  localparam logic [7:0] REG_RST = 8'h00;
  // ==========================================================
  // Prescale terminal counts: period multiplier minus one
  localparam logic [5:0] PRE_X64 = 6'h3F;
  localparam logic [5:0] PRE_X16 = 6'h0F;
  localparam logic [5:0] PRE_X4 = 6'h03;
  localparam logic [5:0] PRE_ZERO = 6'h00;
  localparam logic [15:0] TMR_ZERO = 16'h0000;
  // ==========================================================
  // Mode fields steering the generator
  typedef struct packed {
    logic sync_mode;
    logic high_speed;
    logic width16;
    logic polarity;
  } sbg_mode_s;
  // APB answer
  typedef struct packed {
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } sbg_apb_rsp_s;
endpackage
